/* common/fan_cfg.svh */
// Offsets, field positions, reset values and timing figures of the
// automatic fan controller. Assumes a single 8-bit register space.
`ifndef FAN_CFG_SVH
`define FAN_CFG_SVH
// ==========================================================
// Register offsets
`define OFS_CFG_ONE 8'h00
`define OFS_CHARS 8'h20
`define OFS_SPEED 8'h22
`define OFS_FILTER 8'h23
`define OFS_LOC_LIM 8'h24
`define OFS_REM_LIM 8'h25
`define OFS_STATUS 8'h28
// ==========================================================
// Reset values
`define RST_CFG_ONE 8'h80
`define RST_CHARS 8'h1D
`define RST_SPEED 8'h05
`define RST_FILTER 8'h10
`define RST_LOC_LIM 8'h42
`define RST_REM_LIM 8'h62
// ==========================================================
// Field positions
`define BIT_AUTO 7
`define FLD_SEL 6:5
`define FLD_SPIN 2:0
`define FLD_FREQ 5:3
`define FLD_RANGE 7:6
`define FLD_MIN 3:0
`define BIT_SPIN_DIS 7
`define FLD_RAMP 6:5
`define FLD_RATE 4:2
`define BIT_FILT_EN 0
// ==========================================================
// Drive period and duty scale
`define PWM_SLOTS 240
`define CODE_MAX 4'hF
`define SPAN_CODE_MAX 3'h4
// ==========================================================
// Timing: spin-up in ms, drive frequency in mHz
`define MS_PER_S 1000
`define SPIN_MS_0 200
`define SPIN_MS_1 400
`define SPIN_MS_2 600
`define SPIN_MS_3 800
`define SPIN_MS_4 1000
`define SPIN_MS_5 2000
`define SPIN_MS_6 4000
`define SPIN_MS_7 8000
`define MHZ_PER_HZ 1000
`define PWM_MHZ_0 11700
`define PWM_MHZ_1 15600
`define PWM_MHZ_2 23400
`define PWM_MHZ_3 31250
`define PWM_MHZ_4 37500
`define PWM_MHZ_5 46900
`define PWM_MHZ_6 62500
`define PWM_MHZ_7 93500
// Updates in 16 s at the slowest sample rate
`define UPD_SPAN_S 16
`endif

/* common/fan_pkg.sv */
// Types of the automatic fan controller.
// Assumes fan_cfg.svh holds all numeric constants.
package fan_pkg;
    // ==========================================================
    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    // ==========================================================
    // Measured temperatures, whole degrees C
    typedef struct packed {
        logic [7:0] local_t;
        logic [7:0] remote_t;
    } temps_t;
    // ==========================================================
    // Spin-up sequence, Gray coded
    typedef enum logic [1:0] {
        SPIN_OFF = 2'b00,
        SPIN_ON = 2'b01,
        SPIN_RUN = 2'b11
    } spin_state_t;
endpackage : fan_pkg

/* design/auto_fan_pwm_control.sv */
// Temperature driven fan pulse-width controller with register port.
// Assumes temperatures are synchronous to clk, in whole degrees C.
`include "fan_cfg.svh"

module auto_fan_pwm_control #(
    parameter int CLK_HZ = 20000000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire fan_pkg::reg_req_t bus_req,
    output logic [7:0] rd_data,
    // Temperature channels
    input wire fan_pkg::temps_t temps,
    output logic temp_sample,
    // Fan side
    output logic fan_pwm,
    output logic [3:0] speed_factor
);

    // ==========================================================
    // Register file
    logic [7:0] cfg_r;
    logic [7:0] chars_r;
    logic [7:0] speed_r;
    logic [7:0] filt_r;
    logic [7:0] loc_lim_r;
    logic [7:0] rem_lim_r;
    logic [7:0] rd_data_r;
    logic [7:0] applied_r;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfg_r <= `RST_CFG_ONE;
            chars_r <= `RST_CHARS;
            speed_r <= `RST_SPEED;
            filt_r <= `RST_FILTER;
            loc_lim_r <= `RST_LOC_LIM;
            rem_lim_r <= `RST_REM_LIM;
        end else if (bus_req.wr) begin
            if (bus_req.addr == `OFS_CFG_ONE) begin
                cfg_r <= bus_req.wdata;
            end else if (bus_req.addr == `OFS_CHARS) begin
                chars_r <= bus_req.wdata;
            end else if (bus_req.addr == `OFS_SPEED) begin
                speed_r <= bus_req.wdata;
            end else if (bus_req.addr == `OFS_FILTER) begin
                filt_r <= bus_req.wdata;
            end else if (bus_req.addr == `OFS_LOC_LIM) begin
                loc_lim_r <= bus_req.wdata;
            end else if (bus_req.addr == `OFS_REM_LIM) begin
                rem_lim_r <= bus_req.wdata;
            end
        end
    end
    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_data_r <= 8'h00;
        end else if (!bus_req.rd) begin
            rd_data_r <= 8'h00;
        end else if (bus_req.addr == `OFS_CFG_ONE) begin
            rd_data_r <= cfg_r;
        end else if (bus_req.addr == `OFS_CHARS) begin
            rd_data_r <= chars_r;
        end else if (bus_req.addr == `OFS_SPEED) begin
            rd_data_r <= speed_r;
        end else if (bus_req.addr == `OFS_FILTER) begin
            rd_data_r <= filt_r;
        end else if (bus_req.addr == `OFS_LOC_LIM) begin
            rd_data_r <= loc_lim_r;
        end else if (bus_req.addr == `OFS_REM_LIM) begin
            rd_data_r <= rem_lim_r;
        end else if (bus_req.addr == `OFS_STATUS) begin
            rd_data_r <= applied_r;
        end else begin
            rd_data_r <= 8'h00;
        end
    end
    assign rd_data = rd_data_r;
    assign speed_factor = 4'h1 << chars_r[`FLD_RANGE];
    // ==========================================================
    // Timing helpers
    function automatic logic [35:0] upd_len(input logic [2:0] c);
        upd_len = (36'(CLK_HZ) * 36'(`UPD_SPAN_S)) >> c;
    endfunction : upd_len
    function automatic logic [31:0] slot_len(input logic [2:0] c);
        logic [63:0] mhz;
        logic [63:0] q;
        mhz = 64'(`PWM_MHZ_0);
        case (c)
            3'h1: mhz = 64'(`PWM_MHZ_1);
            3'h2: mhz = 64'(`PWM_MHZ_2);
            3'h3: mhz = 64'(`PWM_MHZ_3);
            3'h4: mhz = 64'(`PWM_MHZ_4);
            3'h5: mhz = 64'(`PWM_MHZ_5);
            3'h6: mhz = 64'(`PWM_MHZ_6);
            3'h7: mhz = 64'(`PWM_MHZ_7);
            default: mhz = 64'(`PWM_MHZ_0);
        endcase
        q = (64'(CLK_HZ) * 64'(`MHZ_PER_HZ)) / (mhz * 64'(`PWM_SLOTS));
        slot_len = (q == 64'h0) ? 32'h1 : q[31:0];
    endfunction : slot_len
    function automatic logic [39:0] spin_len(input logic [2:0] c);
        logic [39:0] ms;
        ms = 40'(`SPIN_MS_0);
        case (c)
            3'h1: ms = 40'(`SPIN_MS_1);
            3'h2: ms = 40'(`SPIN_MS_2);
            3'h3: ms = 40'(`SPIN_MS_3);
            3'h4: ms = 40'(`SPIN_MS_4);
            3'h5: ms = 40'(`SPIN_MS_5);
            3'h6: ms = 40'(`SPIN_MS_6);
            3'h7: ms = 40'(`SPIN_MS_7);
            default: ms = 40'(`SPIN_MS_0);
        endcase
        spin_len = 40'(CLK_HZ / `MS_PER_S) * ms;
    endfunction : spin_len
    function automatic logic [3:0] loop_code(
        input logic [7:0] t,
        input logic [7:0] lim,
        input logic [3:0] mn
    );
        logic [8:0] tmin;
        logic [8:0] diff;
        logic [2:0] sp;
        logic [9:0] steps;
        logic [10:0] sum;
        tmin = {2'b00, lim[7:3], 2'b00};
        diff = {1'b0, t} - tmin;
        sp = (lim[2:0] > `SPAN_CODE_MAX) ? `SPAN_CODE_MAX : lim[2:0];
        // One code per span/10, i.e. per 0.5 * 2^sp degrees
        steps = {diff, 1'b0} >> sp;
        sum = {1'b0, steps} + {7'h00, mn};
        if ({1'b0, t} < tmin) begin
            loop_code = 4'h0;
        end else if (sum > 11'(`CODE_MAX)) begin
            loop_code = `CODE_MAX;
        end else begin
            loop_code = sum[3:0];
        end
    endfunction : loop_code
    // ==========================================================
    // Temperature update timer and sampling
    logic [35:0] upd_cnt_r;
    logic upd_tick;
    logic temp_sample_r;
    logic [7:0] temp_q [2];
    logic [7:0] lim [2];
    logic [7:0] temp_in [2];
    logic [3:0] ch_code [2];
    assign upd_tick = upd_cnt_r >= upd_len(filt_r[`FLD_RATE]) - 36'h1;
    always_ff @(posedge clk) begin
        if (!rstn || upd_tick) begin
            upd_cnt_r <= 36'h0;
        end else begin
            upd_cnt_r <= upd_cnt_r + 36'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rstn) begin
            temp_sample_r <= 1'b0;
        end else begin
            temp_sample_r <= upd_tick;
        end
    end
    assign temp_sample = temp_sample_r;
    assign temp_in[0] = temps.local_t;
    assign temp_in[1] = temps.remote_t;
    assign lim[0] = loc_lim_r;
    assign lim[1] = rem_lim_r;
    // Channel 0 local, channel 1 remote
    for (genvar g = 0; g < 2; g++) begin : g_chan
        always_ff @(posedge clk) begin
            if (!rstn) begin
                temp_q[g] <= 8'h00;
            end else if (upd_tick) begin
                temp_q[g] <= temp_in[g];
            end
        end
        assign ch_code[g] = loop_code(temp_q[g], lim[g], speed_r[`FLD_MIN]);
    end

    // ==========================================================
    // Target duty
    logic auto_on;
    logic filt_on;
    logic [3:0] tgt_code;
    logic [7:0] tgt_slots;
    logic [7:0] step;
    logic [7:0] prev_r;
    logic [7:0] run_slots;
    assign auto_on = cfg_r[`BIT_AUTO];
    assign filt_on = auto_on && filt_r[`BIT_FILT_EN];
    always_comb begin
        if (!auto_on) begin
            tgt_code = speed_r[`FLD_MIN];
        end else begin
            case (cfg_r[`FLD_SEL])
                2'b11: tgt_code = (ch_code[0] > ch_code[1]) ?
                    ch_code[0] : ch_code[1];
                2'b01: tgt_code = ch_code[0];
                default: tgt_code = ch_code[1];
            endcase
        end
    end
    // Code times 16 slots: 5 gives 80, 15 gives 240
    assign tgt_slots = {tgt_code, 4'h0};
    assign step = 8'h1 << filt_r[`FLD_RAMP];
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prev_r <= 8'h00;
        end else if (!filt_on) begin
            prev_r <= tgt_slots;
        end else if (temp_sample_r) begin
            // Step once the target reflects the fresh sample
            if (prev_r < tgt_slots) begin
                prev_r <= (tgt_slots - prev_r <= step) ?
                    tgt_slots : prev_r + step;
            end else if (prev_r > tgt_slots) begin
                prev_r <= (prev_r - tgt_slots <= step) ?
                    tgt_slots : prev_r - step;
            end
        end
    end
    assign run_slots = filt_on ? prev_r : tgt_slots;
    // ==========================================================
    // Spin-up: full drive for the spin-up time when the fan starts
    fan_pkg::spin_state_t state_r;
    logic [39:0] spin_cnt_r;
    logic spin_dis;
    assign spin_dis = filt_r[`BIT_SPIN_DIS];
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= fan_pkg::SPIN_OFF;
            spin_cnt_r <= 40'h0;
        end else begin
            case (state_r)
                fan_pkg::SPIN_OFF: begin
                    if (run_slots != 8'h00 && !spin_dis) begin
                        state_r <= fan_pkg::SPIN_ON;
                        spin_cnt_r <= spin_len(chars_r[`FLD_SPIN]);
                    end else if (run_slots != 8'h00) begin
                        state_r <= fan_pkg::SPIN_RUN;
                    end
                end
                fan_pkg::SPIN_ON: begin
                    if (run_slots == 8'h00) begin
                        state_r <= fan_pkg::SPIN_OFF;
                    end else if (spin_cnt_r <= 40'h1) begin
                        state_r <= fan_pkg::SPIN_RUN;
                    end else begin
                        spin_cnt_r <= spin_cnt_r - 40'h1;
                    end
                end
                fan_pkg::SPIN_RUN: begin
                    if (run_slots == 8'h00) begin
                        state_r <= fan_pkg::SPIN_OFF;
                    end
                end
                default: state_r <= fan_pkg::SPIN_OFF;
            endcase
        end
    end
    logic [7:0] duty_src;
    assign duty_src = (state_r == fan_pkg::SPIN_ON) ?
        8'(`PWM_SLOTS) : run_slots;

    // ==========================================================
    // Drive period: slot divider and 240 slot counter
    logic [31:0] slot_div_r;
    logic slot_tick;
    logic [7:0] slot_cnt_r;
    logic period_end;
    logic pwm_r;

    assign slot_tick = slot_div_r >= slot_len(chars_r[`FLD_FREQ]) - 32'h1;
    assign period_end = slot_tick && slot_cnt_r == 8'(`PWM_SLOTS - 1);

    always_ff @(posedge clk) begin
        if (!rstn || slot_tick) begin
            slot_div_r <= 32'h0;
        end else begin
            slot_div_r <= slot_div_r + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || period_end) begin
            slot_cnt_r <= 8'h00;
        end else if (slot_tick) begin
            slot_cnt_r <= slot_cnt_r + 8'h01;
        end
    end

    // Latched only at the period boundary, so no period mixes counts
    always_ff @(posedge clk) begin
        if (!rstn) begin
            applied_r <= 8'h00;
        end else if (period_end) begin
            applied_r <= duty_src;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pwm_r <= 1'b0;
        end else begin
            pwm_r <= slot_cnt_r < applied_r;
        end
    end

    assign fan_pwm = pwm_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_auto_reset: assert property (
        !$past(rstn) |-> cfg_r[`BIT_AUTO] && cfg_r[`FLD_SEL] == 2'b00)
        else $error("Automatic mode not set after reset");
    a_faster_loop: assert property (
        auto_on && cfg_r[`FLD_SEL] == 2'b11 |-> tgt_code ==
        ((ch_code[0] > ch_code[1]) ? ch_code[0] : ch_code[1]))
        else $error("Faster loop not selected");
    a_remote_only: assert property (
        auto_on && cfg_r[`FLD_SEL] == 2'b00 |-> tgt_code == ch_code[1])
        else $error("Remote loop not driving fan");
    a_spin_load: assert property (
        state_r == fan_pkg::SPIN_OFF && run_slots != 8'h00 && !spin_dis
        |=> state_r == fan_pkg::SPIN_ON &&
        spin_cnt_r == spin_len($past(chars_r[`FLD_SPIN])))
        else $error("Spin-up time not loaded");
    a_slot_range: assert property (
        slot_cnt_r < 8'(`PWM_SLOTS) && applied_r <= 8'(`PWM_SLOTS))
        else $error("Slot count out of range");
    a_pwm_rise: assert property (
        $rose(pwm_r) |-> $past(slot_cnt_r) == 8'h00)
        else $error("Drive rose away from period start");
    a_pwm_fall: assert property (
        $fell(pwm_r) |-> $past(slot_cnt_r) == $past(applied_r))
        else $error("Drive high for wrong slot count");
    a_duty_hold: assert property (
        !$past(period_end) |-> $stable(applied_r))
        else $error("Duty changed inside a period");
    a_ramp_up: assert property (
        filt_on && temp_sample_r && prev_r < tgt_slots |=> prev_r ==
        (($past(tgt_slots) - $past(prev_r) <= $past(step)) ?
        $past(tgt_slots) : $past(prev_r) + $past(step)))
        else $error("Ramp up step wrong");
    a_ramp_hold: assert property (
        filt_on && !temp_sample_r && $stable(filt_on) |=> $stable(prev_r))
        else $error("Filtered duty moved between updates");
    a_below_start: assert property (
        {1'b0, temp_q[1]} < {2'b00, rem_lim_r[7:3], 2'b00}
        |-> ch_code[1] == 4'h0)
        else $error("Duty nonzero below start temperature");
    a_direct_duty: assert property (
        !filt_on && state_r == fan_pkg::SPIN_RUN |-> duty_src == tgt_slots)
        else $error("Unfiltered duty not applied directly");

    c_spin_done: cover property (
        state_r == fan_pkg::SPIN_ON ##1 state_r == fan_pkg::SPIN_RUN);
    c_filt_step: cover property (
        filt_on && temp_sample_r && prev_r != tgt_slots);
    c_third_duty: cover property (period_end && duty_src == 8'h50);
    c_max_mode: cover property (
        auto_on && cfg_r[`FLD_SEL] == 2'b11 && ch_code[0] != ch_code[1]);

endmodule : auto_fan_pwm_control

/* verification/fan_model.sv */
// Fan load on the drive output: counts drive-high clocks in a window.
// Assumes one slot per clock, so the window spans one drive period.
module fan_model #(
    parameter int WIN = 240
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Drive from the controller
    input wire logic fan_pwm,
    // High slots seen over the last window
    output logic [8:0] high_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [WIN-1:0] hist_r;
    // ==========================================================
    // Drive history
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hist_r <= '0;
        end else begin
            hist_r <= {hist_r[WIN-2:0], fan_pwm};
        end
    end
    assign high_cnt = 9'($countones(hist_r));
endmodule : fan_model

/* verification/tb_auto_fan_pwm_control.sv */
// Self-checking bench of the automatic fan pulse-width controller.
// Assumes CLK_HZ of 2400, so one drive slot lasts one clock.
`include "fan_cfg.svh"

`define CHK(nm, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) begin \
            n_errors++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
        end \
    end

module tb_auto_fan_pwm_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CLK_HZ = 2400;
    localparam int LIM = 40000;
    // ==========================================================
    // Signals and tables
    logic clk = 1'b0;
    logic rstn = 1'b0;
    fan_pkg::reg_req_t bus_req = '0;
    fan_pkg::temps_t temps = '0;
    logic [7:0] rd_data;
    logic temp_sample;
    logic fan_pwm;
    logic [3:0] speed_factor;
    logic [8:0] high_cnt;
    int n_errors = 0;
    int compares = 0;
    int e;
    int n;
    logic [7:0] ofs [6] = '{`OFS_CFG_ONE, `OFS_CHARS, `OFS_SPEED,
        `OFS_FILTER, `OFS_LOC_LIM, `OFS_REM_LIM};
    logic [7:0] rst_v [6] = '{8'h80, 8'h1D, 8'h05, 8'h10, 8'h42, 8'h62};
    // Config, local, remote, expected code
    int ac [7][4] = '{'{8'h80, 120, 20, 0}, '{8'h80, 0, 32, 5},
        '{8'h80, 0, 44, 8}, '{8'h80, 0, 100, 15}, '{8'hA0, 40, 100, 9},
        '{8'hE0, 40, 32, 9}, '{8'hE0, 20, 36, 6}};
    // Ramp code, remote, expected slots
    int fc [10][3] = '{'{0, 32, 1}, '{0, 32, 2}, '{0, 32, 3},
        '{3, 32, 11}, '{3, 32, 16}, '{1, 0, 14}, '{1, 0, 12},
        '{2, 0, 8}, '{2, 0, 4}, '{2, 0, 0}};

    always #25 clk = ~clk;

    auto_fan_pwm_control #(.CLK_HZ(CLK_HZ)) auto_fan_pwm_control_inst (
        .clk(clk),
        .rstn(rstn),
        .bus_req(bus_req),
        .rd_data(rd_data),
        .temps(temps),
        .temp_sample(temp_sample),
        .fan_pwm(fan_pwm),
        .speed_factor(speed_factor)
    );

    fan_model fan_model_inst (
        .clk(clk),
        .rstn(rstn),
        .fan_pwm(fan_pwm),
        .high_cnt(high_cnt)
    );
    // ==========================================================
    // Register port and checks
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : reg_wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        `CHK("rd_data", x, rd_data)
    endtask : rd_chk

    task automatic wait_upd();
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (temp_sample !== 1'b1 && n < LIM);
        if (n >= LIM) begin
            n_errors++;
            final_report();
        end
    endtask : wait_upd

    task automatic duty_chk(input int x, input bit upd);
        if (upd) wait_upd();
        repeat (520) @(posedge clk);
        #1;
        `CHK("duty_slots", 9'(x), high_cnt)
    endtask : duty_chk

    task automatic final_report();
        if (n_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    // ==========================================================
    // Tests
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd_chk(ofs[i], rst_v[i]);
        end
        for (int i = 0; i < 6; i++) begin
            reg_wr(ofs[i], ~rst_v[i]);
            rd_chk(ofs[i], ~rst_v[i]);
        end
        reg_wr(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h00);
        for (int r = 3; r >= 0; r--) begin
            reg_wr(`OFS_CHARS, {r[1:0], 6'h1D});
            #1;
            `CHK("speed_factor", 4'(1 << r), speed_factor)
        end
        // Spin-up from stop at full drive
        reg_wr(`OFS_FILTER, 8'h18);
        reg_wr(`OFS_CHARS, 8'h19);
        reg_wr(`OFS_SPEED, 8'h00);
        duty_chk(0, 1'b0);
        reg_wr(`OFS_SPEED, 8'h05);
        duty_chk(240, 1'b0);
        repeat (400) @(posedge clk);
        duty_chk(80, 1'b0);
        // Software duty codes
        wait_upd();
        reg_wr(`OFS_FILTER, 8'h98);
        reg_wr(`OFS_CFG_ONE, 8'h00);
        for (int c = 0; c < 16; c++) begin
            reg_wr(`OFS_SPEED, 8'(c));
            duty_chk(c * 16, 1'b0);
            rd_chk(`OFS_STATUS, 8'(c * 16));
        end
        // Automatic loop, unfiltered
        reg_wr(`OFS_SPEED, 8'h05);
        reg_wr(`OFS_LOC_LIM, 8'h42);
        reg_wr(`OFS_REM_LIM, 8'h43);
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            temps <= '{local_t: 8'(ac[i][1]), remote_t: 8'(ac[i][2])};
            reg_wr(`OFS_CFG_ONE, 8'(ac[i][0]));
            duty_chk(ac[i][3] * 16, 1'b1);
        end
        for (int s = 0; s < 5; s++) begin
            e = 5 + (20 >> s);
            if (e > 15) e = 15;
            for (int k = 0; k < 2; k++) begin
                reg_wr(`OFS_LOC_LIM, {(k != 0) ? 5'h08 : 5'h1F, 3'(s)});
                reg_wr(`OFS_REM_LIM, {(k != 0) ? 5'h1F : 5'h08, 3'(s)});
                @(posedge clk);
                temps <= (k != 0) ? 16'h2A00 : 16'h002A;
                duty_chk(e * 16, 1'b1);
            end
        end
        // Filtered ramping
        reg_wr(`OFS_CFG_ONE, 8'h80);
        reg_wr(`OFS_SPEED, 8'h01);
        reg_wr(`OFS_REM_LIM, 8'h43);
        @(posedge clk);
        temps <= '0;
        duty_chk(0, 1'b1);
        for (int i = 0; i < 10; i++) begin
            reg_wr(`OFS_FILTER, 8'h99 | 8'(fc[i][0] << 5));
            @(posedge clk);
            temps <= {8'h00, 8'(fc[i][1])};
            duty_chk(fc[i][2], 1'b1);
        end
        // Temperature update spacing
        for (int r = 7; r > 3; r--) begin
            wait_upd();
            reg_wr(`OFS_FILTER, 8'h80 | 8'(r << 2));
            wait_upd();
            wait_upd();
            `CHK("upd_period", (CLK_HZ * 16) >> r, n)
        end
        final_report();
    end
    // ==========================================================
    // Watchdog
    initial begin
        repeat (80000) @(posedge clk);
        n_errors++;
        final_report();
    end
endmodule : tb_auto_fan_pwm_control
